/* File: logic/duart_interrupt_control.sv */
// Interrupt control and host strobe qualification for a dual UART.
// Assumes queue, break, counter and input detect logic on ref_clk.
// Overview of operation
// [RULE1] Chip enable ORed with each strobe; later starts, earlier ends.
// [RULE2] One active-low interrupt output for eight masked event sources.
// [RULE3] Software mask register enables each source onto the interrupt.
// [RULE4] Status register shows every active condition, masked or not.
// [RULE5] Output pins three to seven can carry discrete interrupts.
// [RULE6] An interrupt-assigned output pin becomes open-drain active low.
// [RULE7] Receive interrupt drops after a queue read ends the condition.
// [RULE8] Transmit interrupt drops after a queue write ends the condition.
// [RULE9] Break-change interrupt clears only by its reset command.
// [RULE10] Counter interrupt clears by the stop counter command.
// [RULE11] Input-change interrupt clears by reading the change register.
// [RULE12] Clearing a mask bit removes that source at once.
// [RULE13] Host leaves read strobe high long enough before trusting status.
// [RULE14] Reading the change register clears its change bits.
// [RULE15] Reset drives the interrupt inactive and clears all enables.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module duart_interrupt_control
  import duart_irq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic chipEnableN,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic [3:0] busAddr,
  input wire logic [7:0] busDataIn,
  output logic [7:0] busDataOut,
  output logic busDataOe,
  input wire logic [1:0] txRoomAvailable,
  input wire logic [1:0] rxReadyOrFull,
  input wire logic [1:0] breakChangeEvent,
  input wire logic counterEvent,
  input wire logic [3:0] inputLevel,
  input wire logic [3:0] inputChangeEvent,
  input wire logic [7:0] rxDataA,
  input wire logic [7:0] rxDataB,
  output logic [1:0] rxQueueRead,
  output logic [1:0] txQueueWrite,
  output logic [7:0] txData,
  output logic counterRun,
  output logic irqOutN,
  output logic [4:0] outPinData,
  output logic [4:0] outPinOe,
  output logic eventIrq
);

  strobe_if rdIf ();
  strobe_if wrIf ();

  bus_state_t busState_reg;
  logic [3:0] addrPipe_reg [BUS_PIPE_STAGES];
  logic [7:0] dataPipe_reg [BUS_PIPE_STAGES];
  logic [3:0] cycleAddr_reg;
  logic [7:0] writeData_reg;
  logic readDone;
  logic writeDone;
  cmd_t cmdCode;
  logic cmdChan;
  logic [7:0] readValue;
  logic [1:0] breakLatch_reg;
  logic counterLatch_reg;
  logic [3:0] changeBits_reg;
  logic [7:0] mask_reg;
  logic [4:0] outConfig_reg;
  logic [4:0] outData_reg;
  logic [7:0] statusVec;
  logic [7:0] statusPrev_reg;
  logic [7:0] eventStatus_reg;
  logic [7:0] eventMask_reg;
  logic [4:0] pinIrq;

  // ****************************************************************
  // Strobe qualification
  // ****************************************************************
  // Same qualifier for both strobes; chip enable is shared
  strobe_qualifier readQual (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .chipEnableN(chipEnableN),
    .strobeN(readStrobeN),
    .qual(rdIf)
  );

  strobe_qualifier writeQual (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .chipEnableN(chipEnableN),
    .strobeN(writeStrobeN),
    .qual(wrIf)
  );

  // Address and data delayed to line up with the qualified strobes;
  // the first stage only feeds the second
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < BUS_PIPE_STAGES; i++)
      begin
        addrPipe_reg[i] <= 4'h0;
        dataPipe_reg[i] <= 8'h00;
      end
    end
    else
    begin
      addrPipe_reg[0] <= busAddr;
      dataPipe_reg[0] <= busDataIn;
      for (int i = 1; i < BUS_PIPE_STAGES; i++)
      begin
        addrPipe_reg[i] <= addrPipe_reg[i-1];
        dataPipe_reg[i] <= dataPipe_reg[i-1];
      end
    end
  end

  // ****************************************************************
  // Bus cycle state machine
  // ****************************************************************
  // Address is held only briefly, so it is caught at the start
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      busState_reg <= BUS_IDLE;
      cycleAddr_reg <= 4'h0;
    end
    else
    begin
      case (busState_reg)
        BUS_IDLE:
        begin
          if (rdIf.start)
          begin
            busState_reg <= BUS_READ;
            cycleAddr_reg <= addrPipe_reg[BUS_PIPE_STAGES-1];
          end
          else if (wrIf.start)
          begin
            busState_reg <= BUS_WRITE;
            cycleAddr_reg <= addrPipe_reg[BUS_PIPE_STAGES-1];
          end
        end
        BUS_READ:
        begin
          if (rdIf.done)
            busState_reg <= BUS_IDLE;
        end
        BUS_WRITE:
        begin
          if (wrIf.done)
            busState_reg <= BUS_IDLE;
        end
        default:
          busState_reg <= BUS_IDLE;
      endcase
    end
  end

  // Write data tracks the bus until the strobe is seen to rise
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      writeData_reg <= 8'h00;
    else if (busState_reg == BUS_WRITE && wrIf.active)
      writeData_reg <= dataPipe_reg[BUS_PIPE_STAGES-1];
  end

  // Side effects act at cycle end so read data stays steady
  assign readDone = (busState_reg == BUS_READ) && rdIf.done; // [RULE13]
  assign writeDone = (busState_reg == BUS_WRITE) && wrIf.done;
  assign cmdCode = cmd_t'(writeData_reg[7:4]);
  assign cmdChan = writeData_reg[0];

  // ****************************************************************
  // Event sources and status
  // ****************************************************************
  // Break change latches; only the reset command clears, set wins
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      breakLatch_reg <= 2'b00;
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (breakChangeEvent[c])
          breakLatch_reg[c] <= 1'b1;
        else if (writeDone && cycleAddr_reg == ADDR_COMMAND &&
                 cmdCode == CMD_RESET_BREAK && cmdChan == c[0])
          breakLatch_reg[c] <= 1'b0; // [RULE9]
      end
    end
  end

  // Counter event latch and run flag
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      counterLatch_reg <= 1'b0;
      counterRun <= 1'b0;
    end
    else
    begin
      if (counterEvent)
        counterLatch_reg <= 1'b1;
      else if (writeDone && cycleAddr_reg == ADDR_COMMAND &&
               cmdCode == CMD_STOP_CTR)
        counterLatch_reg <= 1'b0; // [RULE10]
      if (writeDone && cycleAddr_reg == ADDR_COMMAND)
      begin
        if (cmdCode == CMD_START_CTR)
          counterRun <= 1'b1;
        else if (cmdCode == CMD_STOP_CTR)
          counterRun <= 1'b0;
      end
    end
  end

  // Change bits clear on a read of their register; a new change wins
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      changeBits_reg <= 4'h0;
    else if (readDone && cycleAddr_reg == ADDR_INPUT_CHANGE)
      changeBits_reg <= inputChangeEvent; // [RULE14] [RULE11]
    else
      changeBits_reg <= changeBits_reg | inputChangeEvent;
  end

  // Queue levels come from the queues and fall after pop or push
  always_comb
  begin
    statusVec = 8'h00;
    statusVec[SRC_TX_A] = txRoomAvailable[0];
    statusVec[SRC_RX_A] = rxReadyOrFull[0];
    statusVec[SRC_BRK_A] = breakLatch_reg[0];
    statusVec[SRC_CTR] = counterLatch_reg;
    statusVec[SRC_TX_B] = txRoomAvailable[1];
    statusVec[SRC_RX_B] = rxReadyOrFull[1];
    statusVec[SRC_BRK_B] = breakLatch_reg[1];
    statusVec[SRC_IPC] = |changeBits_reg;
  end

  // ****************************************************************
  // Queue strobes
  // ****************************************************************
  // One-cycle pop and push pulses to the channel queues
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rxQueueRead <= 2'b00;
      txQueueWrite <= 2'b00;
      txData <= 8'h00;
    end
    else
    begin
      rxQueueRead[0] <= readDone && cycleAddr_reg == ADDR_QUEUE_A; // [RULE7]
      rxQueueRead[1] <= readDone && cycleAddr_reg == ADDR_QUEUE_B; // [RULE7]
      txQueueWrite[0] <= writeDone && cycleAddr_reg == ADDR_QUEUE_A; // [RULE8]
      txQueueWrite[1] <= writeDone && cycleAddr_reg == ADDR_QUEUE_B; // [RULE8]
      if (writeDone)
        txData <= writeData_reg;
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  // Mask, pin configuration, pin data and event mask writes
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      mask_reg <= MASK_RESET; // [RULE15]
      outConfig_reg <= OUT_CONFIG_RESET;
      outData_reg <= OUT_DATA_RESET;
      eventMask_reg <= MASK_RESET;
    end
    else if (writeDone)
    begin
      case (cycleAddr_reg)
        ADDR_MASK:
          mask_reg <= writeData_reg; // [RULE3]
        ADDR_OUT_CONFIG:
          outConfig_reg <= writeData_reg[7:3];
        ADDR_OUT_DATA:
          outData_reg <= writeData_reg[7:3];
        ADDR_EVENT_MASK:
          eventMask_reg <= writeData_reg;
        default:
          mask_reg <= mask_reg;
      endcase
    end
  end

  // Read multiplexer; unmapped offsets read as zero
  always_comb
  begin
    case (cycleAddr_reg)
      ADDR_QUEUE_A:
        readValue = rxDataA;
      ADDR_QUEUE_B:
        readValue = rxDataB;
      ADDR_MASK:
        readValue = mask_reg;
      ADDR_STATUS:
        readValue = statusVec; // [RULE4]
      ADDR_INPUT_CHANGE:
        readValue = {changeBits_reg, inputLevel};
      ADDR_OUT_CONFIG:
        readValue = {outConfig_reg, 3'b000};
      ADDR_OUT_DATA:
        readValue = {outData_reg, 3'b000};
      ADDR_EVENT_STATUS:
        readValue = eventStatus_reg;
      ADDR_EVENT_MASK:
        readValue = eventMask_reg;
      default:
        readValue = READ_UNMAPPED;
    endcase
  end

  // Data bus driven for the whole read cycle, live values
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      busDataOut <= 8'h00;
      busDataOe <= 1'b0;
    end
    else
    begin
      busDataOe <= (busState_reg == BUS_READ) && !rdIf.done;
      // Zero on the closing edge too, so data never outlives the enable
      busDataOut <= (busState_reg == BUS_READ) && !rdIf.done ? readValue
        : 8'h00;
    end
  end

  // ****************************************************************
  // Interrupt outputs
  // ****************************************************************
  // Shared output follows status and mask each cycle, so a cleared
  // enable drops its source on the next edge
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      irqOutN <= 1'b1; // [RULE15]
    else
      irqOutN <= ~|(statusVec & mask_reg); // [RULE2] [RULE12]
  end

  // Discrete sources for pins 3..7: counter, rx A, rx B, tx A, tx B;
  // these are not masked, as each pin serves a single source
  assign pinIrq = {statusVec[SRC_TX_B], statusVec[SRC_TX_A],
                   statusVec[SRC_RX_B], statusVec[SRC_RX_A],
                   statusVec[SRC_CTR]};

  // Interrupt pins only pull low; data pins drive the complement
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      outPinData <= 5'h1f;
      outPinOe <= 5'h1f;
    end
    else
    begin
      for (int p = 0; p < 5; p++)
      begin
        if (outConfig_reg[p])
        begin
          outPinData[p] <= 1'b0; // [RULE6]
          outPinOe[p] <= pinIrq[p]; // [RULE5] [RULE6]
        end
        else
        begin
          outPinData[p] <= ~outData_reg[p];
          outPinOe[p] <= 1'b1;
        end
      end
    end
  end

  // Sticky record of rising conditions, cleared by its read;
  // an edge in the clearing cycle is kept
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      statusPrev_reg <= 8'h00;
      eventStatus_reg <= 8'h00;
    end
    else
    begin
      statusPrev_reg <= statusVec;
      if (readDone && cycleAddr_reg == ADDR_EVENT_STATUS)
        eventStatus_reg <= statusVec & ~statusPrev_reg;
      else
        eventStatus_reg <= eventStatus_reg | (statusVec & ~statusPrev_reg);
    end
  end

  // Level output while any unmasked sticky bit stands
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      eventIrq <= 1'b0;
    else
      eventIrq <= |(eventStatus_reg & eventMask_reg);
  end

endmodule : duart_interrupt_control

/* File: logic/duart_irq_pkg.sv */
// Constants, field positions and types for the interrupt control block.
// Assumes one 200 MHz clock and a 4-bit host address bus.
package duart_irq_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  // Interrupt negation deadline after the clearing host action
  localparam int IRQ_NEGATE_MAX_NS = 100;
  localparam int IRQ_NEGATE_CYCLES = (IRQ_NEGATE_MAX_NS * 1000)
    / CLK_PERIOD_PS;
  // Least strobe high time between accesses
  localparam int BUS_GAP_MIN_NS = 30;
  localparam int BUS_GAP_CYCLES = (BUS_GAP_MIN_NS * 1000
    + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Least strobe low time
  localparam int STROBE_MIN_NS = 70;
  localparam int STROBE_MIN_CYCLES = (STROBE_MIN_NS * 1000
    + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SYNC_STAGES = 3;
  // Address and data lag the strobes by two more stages
  localparam int BUS_PIPE_STAGES = SYNC_STAGES + 2;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [3:0] ADDR_QUEUE_A = 4'h0;
  localparam logic [3:0] ADDR_QUEUE_B = 4'h1;
  localparam logic [3:0] ADDR_COMMAND = 4'h2;
  localparam logic [3:0] ADDR_MASK = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_INPUT_CHANGE = 4'h5;
  localparam logic [3:0] ADDR_OUT_CONFIG = 4'h6;
  localparam logic [3:0] ADDR_OUT_DATA = 4'h7;
  localparam logic [3:0] ADDR_EVENT_STATUS = 4'h8;
  localparam logic [3:0] ADDR_EVENT_MASK = 4'h9;

  // ****************************************************************
  // Event source positions in the status and mask registers
  // ****************************************************************
  localparam int NUM_SOURCES = 8;
  localparam int SRC_TX_A = 0;
  localparam int SRC_RX_A = 1;
  localparam int SRC_BRK_A = 2;
  localparam int SRC_CTR = 3;
  localparam int SRC_TX_B = 4;
  localparam int SRC_RX_B = 5;
  localparam int SRC_BRK_B = 6;
  localparam int SRC_IPC = 7;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [4:0] OUT_CONFIG_RESET = 5'h00;
  localparam logic [4:0] OUT_DATA_RESET = 5'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Command codes sit in write data bits 7:4, channel in bit 0
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_RESET_BREAK = 4'h5,
    CMD_START_CTR = 4'h8,
    CMD_STOP_CTR = 4'h9
  } cmd_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_READ = 2'b01,
    BUS_WRITE = 2'b10
  } bus_state_t;

endpackage : duart_irq_pkg

/* File: logic/strobe_if.sv */
// Qualified strobe bundle between the strobe qualifier and the core.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ps
interface strobe_if;
  logic active;
  logic start;
  logic done;
  modport source (output active, output start, output done);
  modport sink (input active, input start, input done);
endinterface : strobe_if

/* File: logic/strobe_qualifier.sv */
// Synchronises chip enable and one strobe pin and combines them.
// Assumes both pins are asynchronous to ref_clk and active low.
`timescale 1ns/1ps
module strobe_qualifier
  import duart_irq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic chipEnableN,
  input wire logic strobeN,
  strobe_if.source qual
);

  logic [SYNC_STAGES-1:0] ceSync_reg;
  logic [SYNC_STAGES-1:0] stSync_reg;
  logic ceStable_reg;
  logic stStable_reg;
  logic cycle;
  logic active_reg;
  logic start_reg;
  logic done_reg;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Shift chains; the first stage feeds only the second
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ceSync_reg <= '1;
      stSync_reg <= '1;
    end
    else
    begin
      ceSync_reg <= {ceSync_reg[SYNC_STAGES-2:0], chipEnableN};
      stSync_reg <= {stSync_reg[SYNC_STAGES-2:0], strobeN};
    end
  end

  // A level counts once the second and third stage agree
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ceStable_reg <= 1'b1;
      stStable_reg <= 1'b1;
    end
    else
    begin
      if (ceSync_reg[1] == ceSync_reg[2])
        ceStable_reg <= ceSync_reg[2];
      if (stSync_reg[1] == stSync_reg[2])
        stStable_reg <= stSync_reg[2];
    end
  end

  // ****************************************************************
  // Cycle framing
  // ****************************************************************
  // Later assertion opens, earlier negation closes the cycle
  assign cycle = ~(ceStable_reg | stStable_reg); // [RULE1]

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      active_reg <= 1'b0;
      start_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      active_reg <= cycle;
      start_reg <= cycle & ~active_reg;
      done_reg <= ~cycle & active_reg;
    end
  end

  assign qual.active = active_reg;
  assign qual.start = start_reg;
  assign qual.done = done_reg;

endmodule : strobe_qualifier

/* File: verification/duart_interrupt_control_props.sv */
// Port-level checks for the interrupt control block.
// Assumes binding into duart_interrupt_control on the single ref_clk.
`timescale 1ns/1ps
module duart_interrupt_control_props
  import duart_irq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic chipEnableN,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic [7:0] busDataOut,
  input wire logic busDataOe,
  input wire logic [1:0] rxQueueRead,
  input wire logic [1:0] txQueueWrite,
  input wire logic counterRun,
  input wire logic irqOutN,
  input wire logic [4:0] outPinOe,
  input wire logic eventIrq
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Pin checks look three edges back: the synchroniser hides younger edges
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Reset checks override the default, they watch reset itself
  AST_RESET_IRQ: assert property (disable iff (1'b0)
    !rst_n |=> irqOutN && !eventIrq)
    else $error("interrupt active after reset edge");
  AST_RESET_PINS: assert property (disable iff (1'b0)
    !rst_n |=> outPinOe == 5'h1f && !busDataOe && !counterRun)
    else $error("outputs not idle after reset edge");
  AST_DATA_ZERO: assert property (
    !busDataOe |-> busDataOut == 8'h00)
    else $error("read data shown outside a read cycle");
  AST_OE_START: assert property (
    $rose(busDataOe) |-> $past(!readStrobeN && !chipEnableN, 3))
    else $error("data drive began without both pins low");
  AST_OE_END: assert property (
    $fell(busDataOe) |-> $past(readStrobeN || chipEnableN, 3))
    else $error("data drive ended while both pins low");
  AST_POP_AFTER_END: assert property (
    |rxQueueRead |-> $past(readStrobeN || chipEnableN, 3))
    else $error("queue pop before read cycle ended");
  AST_POP_PULSE: assert property (
    |rxQueueRead |=> rxQueueRead == 2'b00)
    else $error("queue pop longer than one cycle");
  AST_PUSH_AFTER_END: assert property (
    |txQueueWrite |-> $past(writeStrobeN || chipEnableN, 3))
    else $error("queue push before write cycle ended");
  AST_RUN_STOP: assert property (
    $fell(counterRun) |-> $past(writeStrobeN || chipEnableN, 3))
    else $error("counter stopped without a finished write");

  // Main scenarios reached
  cover property ($fell(irqOutN));
  cover property ($rose(busDataOe));
  cover property (txQueueWrite[0]);
  cover property ($fell(counterRun));
endmodule : duart_interrupt_control_props

bind duart_interrupt_control duart_interrupt_control_props
  duart_interrupt_control_props_i (.ref_clk, .rst_n, .chipEnableN,
  .readStrobeN, .writeStrobeN, .busDataOut, .busDataOe, .rxQueueRead,
  .txQueueWrite, .counterRun, .irqOutN, .outPinOe, .eventIrq);

/* File: verification/host_bus_model.sv */
// Host processor model on the asynchronous parallel bus.
// Assumes the bench calls access() from one process at a time.
`timescale 1ns/1ps
module host_bus_model
  import duart_irq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [7:0] busDataOut,
  input wire logic busDataOe,
  output logic chipEnableN = 1'b1,
  output logic readStrobeN = 1'b1,
  output logic writeStrobeN = 1'b1,
  output logic [3:0] busAddr = 4'h0,
  output logic [7:0] busDataIn = 8'h00
);
  // ****************************************************************
  // Bus cycle
  // ****************************************************************
  // Writes start on the strobe, reads on chip enable, so both orders run
  task automatic access(input logic isWrite, input logic [3:0] addr,
    input logic [7:0] wdata, output logic [7:0] rdata);
    @(posedge ref_clk);
    busAddr <= addr;
    busDataIn <= wdata;
    if (isWrite)
      chipEnableN <= 1'b0;
    else
      readStrobeN <= 1'b0;
    @(posedge ref_clk);
    if (isWrite)
      writeStrobeN <= 1'b0;
    else
      chipEnableN <= 1'b0;
    repeat (14) @(posedge ref_clk);
    rdata = busDataOe ? busDataOut : 8'hxx;
    writeStrobeN <= 1'b1;
    readStrobeN <= 1'b1;
    @(posedge ref_clk);
    chipEnableN <= 1'b1;
    // Released lines show the inverse, never a stale copy
    busAddr <= ~addr;
    busDataIn <= ~wdata;
    // Long gap also lets status changes settle before the next read
    repeat (14) @(posedge ref_clk);
  endtask : access
endmodule : host_bus_model

/* File: verification/duart_interrupt_control_tb.sv */
// Self-checking bench for the interrupt control block.
// Assumes host_bus_model and the bound checker are compiled first.
`timescale 1ns/1ps
module duart_interrupt_control_tb
  import duart_irq_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] txRoomAvailable = 2'b00;
  logic [1:0] rxReadyOrFull = 2'b00;
  logic [1:0] breakChangeEvent = 2'b00;
  logic counterEvent = 1'b0;
  logic [3:0] inputLevel = 4'h0;
  logic [3:0] inputChangeEvent = 4'h0;
  logic [7:0] rxDataA = 8'h00;
  logic [7:0] rxDataB = 8'h00;
  logic chipEnableN, readStrobeN, writeStrobeN, busDataOe;
  logic [3:0] busAddr;
  logic [7:0] busDataIn, busDataOut, txData, txSeen, rv;
  logic [1:0] rxQueueRead, txQueueWrite;
  logic counterRun, irqOutN, eventIrq;
  logic [4:0] outPinData, outPinOe;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  always #2.5 ref_clk = ~ref_clk;

  duart_interrupt_control duart_interrupt_control_i (.ref_clk, .rst_n,
    .chipEnableN, .readStrobeN, .writeStrobeN, .busAddr, .busDataIn,
    .busDataOut, .busDataOe, .txRoomAvailable, .rxReadyOrFull,
    .breakChangeEvent, .counterEvent, .inputLevel, .inputChangeEvent,
    .rxDataA, .rxDataB, .rxQueueRead, .txQueueWrite, .txData, .counterRun,
    .irqOutN, .outPinData, .outPinOe, .eventIrq);

  host_bus_model host_bus_model_i (.ref_clk, .busDataOut, .busDataOe,
    .chipEnableN, .readStrobeN, .writeStrobeN, .busAddr, .busDataIn);

  // ****************************************************************
  // Queue side and watchdog
  // ****************************************************************
  // On channel A a push fills the only free slot, a pop empties the only entry
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      print_verdict();
    end
    if (txQueueWrite[0] === 1'b1)
    begin
      txRoomAvailable[0] <= 1'b0;
      txSeen <= txData;
    end
    if (rxQueueRead[0] === 1'b1)
      rxReadyOrFull[0] <= 1'b0;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] r;
    host_bus_model_i.access(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] r);
    host_bus_model_i.access(1'b0, a, 8'h00, r);
  endtask : rd

  task automatic irq(input logic exp);
    chk("irqOutN", {7'h00, exp}, {7'h00, irqOutN});
  endtask : irq

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset();
    irq(1'b1);
    chk("outPinOe", 8'h1f, {3'h0, outPinOe});
    rd(ADDR_MASK, rv);
    chk("mask", MASK_RESET, rv);
  endtask : test_reset

  task automatic test_mask_status();
    txRoomAvailable[0] <= 1'b1;
    rd(ADDR_STATUS, rv);
    chk("status", 8'h01, rv);
    irq(1'b1);
    wr(ADDR_EVENT_MASK, 8'h01);
    chk("eventIrq", 8'h01, {7'h00, eventIrq});
    rd(ADDR_EVENT_STATUS, rv);
    chk("event status", 8'h01, rv);
    chk("eventIrq", 8'h00, {7'h00, eventIrq});
    wr(ADDR_MASK, 8'h01);
    irq(1'b0);
    wr(ADDR_MASK, 8'h00);
    irq(1'b1);
    wr(ADDR_STATUS, 8'hff);
    rd(4'hf, rv);
    chk("unmapped", READ_UNMAPPED, rv);
  endtask : test_mask_status

  task automatic test_tx();
    wr(ADDR_MASK, 8'h01);
    irq(1'b0);
    wr(ADDR_QUEUE_A, 8'h5a);
    chk("txData", 8'h5a, txSeen);
    irq(1'b1);
  endtask : test_tx

  task automatic test_rx();
    rxReadyOrFull[0] <= 1'b1;
    rxDataA <= 8'h3c;
    wr(ADDR_MASK, 8'h02);
    irq(1'b0);
    rd(ADDR_QUEUE_A, rv);
    chk("rx data", 8'h3c, rv);
    irq(1'b1);
  endtask : test_rx

  task automatic test_break();
    breakChangeEvent[0] <= 1'b1;
    @(posedge ref_clk);
    breakChangeEvent[0] <= 1'b0;
    wr(ADDR_MASK, 8'h04);
    rd(ADDR_STATUS, rv);
    chk("status", 8'h04, rv);
    irq(1'b0);
    wr(ADDR_COMMAND, {CMD_RESET_BREAK, 4'h0});
    irq(1'b1);
  endtask : test_break

  task automatic test_counter();
    wr(ADDR_COMMAND, {CMD_START_CTR, 4'h0});
    chk("counterRun", 8'h01, {7'h00, counterRun});
    counterEvent <= 1'b1;
    @(posedge ref_clk);
    counterEvent <= 1'b0;
    wr(ADDR_MASK, 8'h08);
    irq(1'b0);
    wr(ADDR_COMMAND, {CMD_STOP_CTR, 4'h0});
    chk("counterRun", 8'h00, {7'h00, counterRun});
    irq(1'b1);
  endtask : test_counter

  task automatic test_change();
    inputLevel <= 4'h5;
    inputChangeEvent <= 4'h2;
    @(posedge ref_clk);
    inputChangeEvent <= 4'h0;
    wr(ADDR_MASK, 8'h80);
    irq(1'b0);
    rd(ADDR_INPUT_CHANGE, rv);
    chk("change reg", 8'h25, rv);
    irq(1'b1);
    rd(ADDR_INPUT_CHANGE, rv);
    chk("change reg", 8'h05, rv);
  endtask : test_change

  task automatic test_pins();
    wr(ADDR_MASK, 8'h00);
    wr(ADDR_OUT_DATA, 8'hf8);
    chk("outPinData", 8'h00, {3'h0, outPinData});
    chk("outPinOe", 8'h1f, {3'h0, outPinOe});
    wr(ADDR_OUT_CONFIG, 8'hf8);
    rd(ADDR_OUT_CONFIG, rv);
    chk("pin config", 8'hf8, rv);
    rxReadyOrFull[0] <= 1'b1;
    repeat (12) @(posedge ref_clk);
    chk("outPinData", 8'h00, {3'h0, outPinData});
    chk("pin drive", 8'h01, {7'h00, |outPinOe});
    rxReadyOrFull[0] <= 1'b0;
  endtask : test_pins

  task automatic print_verdict();
    if (errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    test_reset();
    test_mask_status();
    test_tx();
    test_rx();
    test_break();
    test_counter();
    test_change();
    test_pins();
    print_verdict();
  end
endmodule : duart_interrupt_control_tb
